// ==== src/hcm_pkg.sv ====
package hcm_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [15:0] HCM_CMD_WORD_ADDR  = 16'h0040;
    localparam logic [15:0] HCM_POOL_BASE_ADDR = 16'hfc00;
    localparam int          HCM_POOL_WORDS     = 8;
    localparam int          HCM_POOL_AW        = 3;
    localparam int          HCM_PEND_BIT       = 15;
    localparam logic [15:0] HCM_RESULT_OK      = 16'h0000;
    localparam logic [15:0] HCM_RESULT_BADCMD  = 16'h0001;
    localparam logic [15:0] HCM_STATE_RESET    = 16'h0000;

    // ************************************************************
    // command codes
    // ************************************************************
    localparam logic [15:0] HCM_SYS_SET        = 16'h8100;
    localparam logic [15:0] HCM_SYS_GET        = 16'h8101;
    localparam logic [15:0] HCM_OVL_FIRST      = 16'h8200;
    localparam logic [15:0] HCM_OVL_LOAD_BUF   = 16'h8206;
    localparam logic [15:0] HCM_OVL_LAST       = 16'h820e;
    localparam logic [15:0] HCM_GPIO_FIRST     = 16'h8400;
    localparam logic [15:0] HCM_GPIO_LAST      = 16'h8405;
    localparam logic [15:0] HCM_FL_GET_LOCK    = 16'h8500;
    localparam logic [15:0] HCM_FL_LOCK_STAT   = 16'h8501;
    localparam logic [15:0] HCM_FL_RELEASE     = 16'h8502;
    localparam logic [15:0] HCM_FL_CONFIG      = 16'h8503;
    localparam logic [15:0] HCM_FL_READ        = 16'h8504;
    localparam logic [15:0] HCM_FL_QUERY       = 16'h8508;
    localparam logic [15:0] HCM_FL_STATUS      = 16'h8509;
    localparam logic [15:0] HCM_FL_CFG_DEV     = 16'h850a;
    localparam logic [15:0] HCM_SEQ_REFRESH    = 16'h8606;
    localparam logic [15:0] HCM_SEQ_REF_STAT   = 16'h8607;
    localparam logic [15:0] HCM_PATCH_LOAD     = 16'h8700;
    localparam logic [15:0] HCM_PATCH_STATUS   = 16'h8701;
    localparam logic [15:0] HCM_PATCH_APPLY    = 16'h8702;
    localparam logic [15:0] HCM_PATCH_RESERVE  = 16'h8706;
    localparam logic [15:0] HCM_UTIL_INVOKE    = 16'h8900;
    localparam logic [15:0] HCM_UTIL_WAIT      = 16'h8902;

    // ************************************************************
    // controller software registers (word index on its own port)
    // ************************************************************
    localparam logic [3:0]  HCM_R_CTRL         = 4'h0;
    localparam logic [3:0]  HCM_R_CODE         = 4'h1;
    localparam logic [3:0]  HCM_R_RESULT       = 4'h2;
    localparam logic [3:0]  HCM_R_STATUS       = 4'h3;
    localparam logic [3:0]  HCM_R_IRQ_STAT     = 4'h4;
    localparam logic [3:0]  HCM_R_IRQ_MASK     = 4'h5;
    localparam logic [3:0]  HCM_R_PARAM0       = 4'h8;
    localparam int          HCM_CTRL_GO        = 0;
    localparam int          HCM_EV_DONE        = 0;
    localparam int          HCM_EV_FAIL        = 1;
    localparam int          HCM_EV_TIMEOUT     = 2;
    localparam int          HCM_EV_W           = 3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          HCM_POLL_DELAY_CYC = 10;
    localparam int          HCM_POLL_TIMEOUT   = 100;
    localparam int          HCM_EXEC_CYC       = 4;
endpackage : hcm_pkg

// ==== src/hcm_link_if.sv ====
`timescale 1ns/1ps
interface hcm_link_if;
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport device (input wr, input rd, input addr, input wdata, output rdata);
    modport host   (output wr, output rd, output addr, output wdata, input rdata);
endinterface : hcm_link_if

// ==== src/hcm_device.sv ====
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module hcm_device
    import hcm_pkg::*;
(
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   srst,
    input  wire logic   ce,
    // host side
    hcm_link_if.device  link,
    // on-chip executor side
    output logic        cmd_irq,
    output logic [15:0] cmd_code,
    output logic        cmd_valid,
    output logic        cmd_async,
    input  wire logic   exec_done,
    input  wire logic [15:0] exec_result,
    input  wire logic   pool_we,
    input  wire logic [HCM_POOL_AW-1:0] pool_waddr,
    input  wire logic [15:0] pool_wdata,
    output logic [15:0] sys_state
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [1:0] {HCM_D_IDLE, HCM_D_EXEC} hcm_dstate_t;

    hcm_dstate_t st_reg, st_next;
    logic [15:0] cmd_reg, cmd_next;
    logic [15:0] pool_reg [HCM_POOL_WORDS];
    logic [15:0] pool_next [HCM_POOL_WORDS];
    logic [15:0] rdata_reg, rdata_next;
    logic [15:0] sys_reg, sys_next;
    logic        valid_reg, valid_next;
    logic        async_reg, async_next;
    logic        known;
    logic        is_async;
    logic        pool_hit;
    logic [HCM_POOL_AW-1:0] pool_idx;
    logic        cmd_hit;
    logic        get_done;

    // ************************************************************
    // decode
    // ************************************************************
    // decode looks at write data directly so a refusal costs no cycle
    always_comb begin
        known = 1'b1;
        is_async = 1'b0;
        if (link.wdata == HCM_SYS_SET || link.wdata == HCM_SYS_GET) begin
            known = 1'b1;
        end else if (link.wdata >= HCM_OVL_FIRST && link.wdata <= HCM_OVL_LAST) begin
            is_async = (link.wdata == HCM_OVL_LOAD_BUF) || (link.wdata == HCM_OVL_LAST);
        end else if (link.wdata >= HCM_GPIO_FIRST && link.wdata <= HCM_GPIO_LAST) begin
            is_async = 1'b0;
        end else if (link.wdata >= HCM_FL_GET_LOCK && link.wdata <= HCM_FL_CFG_DEV) begin
            is_async = (link.wdata == HCM_FL_GET_LOCK)
                || (link.wdata >= HCM_FL_READ && link.wdata <= HCM_FL_QUERY);
        end else if (link.wdata == HCM_SEQ_REFRESH || link.wdata == HCM_SEQ_REF_STAT) begin
            is_async = 1'b0;
        end else if (link.wdata == HCM_PATCH_LOAD || link.wdata == HCM_PATCH_STATUS
                     || link.wdata == HCM_PATCH_APPLY || link.wdata == HCM_PATCH_RESERVE) begin
            is_async = (link.wdata == HCM_PATCH_LOAD) || (link.wdata == HCM_PATCH_APPLY);
        end else if (link.wdata >= HCM_UTIL_INVOKE && link.wdata <= HCM_UTIL_WAIT) begin
            is_async = 1'b0;
        end else begin
            known = 1'b0;
        end
    end

    // pool window is a plain range compare on the word address
    assign pool_hit = (link.addr >= HCM_POOL_BASE_ADDR)
                   && (link.addr < HCM_POOL_BASE_ADDR + 16'(HCM_POOL_WORDS));
    assign pool_idx = link.addr[HCM_POOL_AW-1:0];
    assign cmd_hit  = link.wr && (link.addr == HCM_CMD_WORD_ADDR);
    // a state query leaves its answer in pool word zero at completion
    assign get_done = (st_reg == HCM_D_EXEC) && (cmd_reg == HCM_SYS_GET) && exec_done;

    // ************************************************************
    // read path
    // ************************************************************
    // zero outside the answer cycle, so the link data can be or-ed
    always_comb begin
        rdata_next = 16'h0000;
        if (link.rd) begin
            if (link.addr == HCM_CMD_WORD_ADDR) begin
                rdata_next = cmd_reg;
            end else if (pool_hit) begin
                rdata_next = pool_reg[pool_idx];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_reg <= 16'h0000;
        end else if (ce) begin
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // parameter pool
    // ************************************************************
    // writes are taken even while pending; holding off is the host's duty
    always_comb begin
        pool_next = pool_reg;
        if (pool_we) begin
            pool_next[pool_waddr] = pool_wdata;
        end
        if (link.wr && pool_hit) begin
            pool_next[pool_idx] = link.wdata;
        end
        if (get_done) begin
            pool_next[0] = sys_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pool_reg <= '{default: 16'h0000};
        end else if (ce) begin
            pool_reg <= pool_next;
        end
    end

    // ************************************************************
    // command word
    // ************************************************************
    // one command in flight; its result overwrites the code when done
    always_comb begin
        st_next    = st_reg;
        cmd_next   = cmd_reg;
        sys_next   = sys_reg;
        valid_next = 1'b0;
        async_next = async_reg;
        unique case (st_reg)
            HCM_D_IDLE: begin
                if (cmd_hit && link.wdata[HCM_PEND_BIT]) begin
                    if (known) begin
                        cmd_next   = link.wdata;
                        valid_next = 1'b1;
                        async_next = is_async;
                        st_next    = HCM_D_EXEC;
                        if (link.wdata == HCM_SYS_SET) begin
                            sys_next = pool_reg[0];
                        end
                    end else begin
                        // refused at once: the executor never sees it
                        cmd_next = HCM_RESULT_BADCMD;
                    end
                end
            end
            HCM_D_EXEC: begin
                // a second command word is dropped while pending
                if (exec_done) begin
                    cmd_next               = exec_result;
                    cmd_next[HCM_PEND_BIT] = 1'b0;
                    st_next                = HCM_D_IDLE;
                end
            end
            default: st_next = HCM_D_IDLE;
        endcase
    end

    // reset ignores the enable so a frozen block can still be cleared
    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg    <= HCM_D_IDLE;
            cmd_reg   <= HCM_RESULT_OK;
            sys_reg   <= HCM_STATE_RESET;
            valid_reg <= 1'b0;
            async_reg <= 1'b0;
        end else if (ce) begin
            st_reg    <= st_next;
            cmd_reg   <= cmd_next;
            sys_reg   <= sys_next;
            valid_reg <= valid_next;
            async_reg <= async_next;
        end
    end

    // cmd_irq is the registered accept pulse, one cycle wide
    assign link.rdata = rdata_reg;
    assign cmd_irq    = valid_reg;
    assign cmd_valid  = (st_reg == HCM_D_EXEC);
    assign cmd_code   = cmd_reg;
    assign cmd_async  = async_reg;
    assign sys_state  = sys_reg;
endmodule : hcm_device

// ==== src/hcm_host.sv ====
`timescale 1ns/1ps
module hcm_host
    import hcm_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        ce,
    // software port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [15:0] sw_rdata,
    output logic             irq,
    // device side
    hcm_link_if.host         link
);
    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {HCM_H_IDLE, HCM_H_PARAM, HCM_H_CMD, HCM_H_WAIT,
                              HCM_H_POLL, HCM_H_CHECK} hcm_hstate_t;

    hcm_hstate_t st_reg, st_next;
    logic [15:0] code_reg, code_next;
    logic [15:0] param_reg, param_next;
    logic [15:0] result_reg, result_next;
    logic [7:0]  dly_reg, dly_next;
    logic [7:0]  tries_reg, tries_next;
    logic [HCM_EV_W-1:0] ev_reg, ev_next, mask_reg, mask_next, ev_set;
    logic [15:0] rd_reg, rd_next;
    logic        busy;

    assign busy = (st_reg != HCM_H_IDLE);

    always_comb begin
        st_next     = st_reg;
        code_next   = code_reg;
        param_next  = param_reg;
        result_next = result_reg;
        dly_next    = dly_reg;
        tries_next  = tries_reg;
        mask_next   = mask_reg;
        ev_set      = '0;
        link.wr     = 1'b0;
        link.rd     = 1'b0;
        link.addr   = 16'h0000;
        link.wdata  = 16'h0000;
        if (sw_wr && sw_addr == HCM_R_CODE && !busy) code_next = sw_wdata;
        if (sw_wr && sw_addr == HCM_R_PARAM0 && !busy) param_next = sw_wdata;
        if (sw_wr && sw_addr == HCM_R_IRQ_MASK) mask_next = sw_wdata[HCM_EV_W-1:0];
        unique case (st_reg)
            HCM_H_IDLE: begin
                // a go written while the last command is unfinished is ignored, not held
                if (sw_wr && sw_addr == HCM_R_CTRL && sw_wdata[HCM_CTRL_GO]) st_next = HCM_H_PARAM;
            end
            HCM_H_PARAM: begin
                link.wr    = 1'b1;
                link.addr  = HCM_POOL_BASE_ADDR;
                link.wdata = param_reg;
                st_next    = HCM_H_CMD;
            end
            HCM_H_CMD: begin
                link.wr    = 1'b1;
                link.addr  = HCM_CMD_WORD_ADDR;
                link.wdata = code_reg;
                tries_next = 8'h00;
                dly_next   = 8'(HCM_POLL_DELAY_CYC);
                st_next    = HCM_H_WAIT;
            end
            HCM_H_WAIT: begin
                dly_next = dly_reg - 8'h01;
                if (dly_reg == 8'h01) st_next = HCM_H_POLL;
            end
            HCM_H_POLL: begin
                link.rd   = 1'b1;
                link.addr = HCM_CMD_WORD_ADDR;
                st_next   = HCM_H_CHECK;
            end
            HCM_H_CHECK: begin
                tries_next = tries_reg + 8'h01;
                if (!link.rdata[HCM_PEND_BIT]) begin
                    result_next = link.rdata;
                    ev_set[HCM_EV_DONE] = 1'b1;
                    ev_set[HCM_EV_FAIL] = (link.rdata != HCM_RESULT_OK);
                    st_next = HCM_H_IDLE;
                end else if (tries_reg == 8'(HCM_POLL_TIMEOUT - 1)) begin
                    ev_set[HCM_EV_TIMEOUT] = 1'b1;
                    st_next = HCM_H_IDLE;
                end else begin
                    dly_next = 8'(HCM_POLL_DELAY_CYC);
                    st_next  = HCM_H_WAIT;
                end
            end
            default: st_next = HCM_H_IDLE;
        endcase
        // set wins over the read-clear
        ev_next = ((sw_rd && sw_addr == HCM_R_IRQ_STAT) ? '0 : ev_reg) | ev_set;
        unique case (sw_addr)
            HCM_R_CODE:     rd_next = code_reg;
            HCM_R_RESULT:   rd_next = result_reg;
            HCM_R_STATUS:   rd_next = {15'h0000, busy};
            HCM_R_IRQ_STAT: rd_next = {13'h0000, ev_reg};
            HCM_R_IRQ_MASK: rd_next = {13'h0000, mask_reg};
            HCM_R_PARAM0:   rd_next = param_reg;
            default:        rd_next = 16'h0000;
        endcase
        if (!sw_rd) rd_next = 16'h0000;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_reg     <= HCM_H_IDLE;
            code_reg   <= 16'h0000;
            param_reg  <= 16'h0000;
            result_reg <= 16'h0000;
            dly_reg    <= 8'h00;
            tries_reg  <= 8'h00;
            ev_reg     <= '0;
            mask_reg   <= '0;
            rd_reg     <= 16'h0000;
        end else if (ce) begin
            st_reg     <= st_next;
            code_reg   <= code_next;
            param_reg  <= param_next;
            result_reg <= result_next;
            dly_reg    <= dly_next;
            tries_reg  <= tries_next;
            ev_reg     <= ev_next;
            mask_reg   <= mask_next;
            rd_reg     <= rd_next;
        end
    end

    assign sw_rdata = rd_reg;
    assign irq      = |(ev_reg & mask_reg);
endmodule : hcm_host

// ==== bench/hcm_link_asserts.sv ====
`timescale 1ns/1ps
module hcm_link_asserts
    import hcm_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // link signals
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (srst);

    // ************************************************************
    // sequences
    // ************************************************************
    sequence cmd_wr;
        wr && addr == HCM_CMD_WORD_ADDR;
    endsequence
    // ten idle cycles before the first poll
    sequence link_quiet;
        (!rd && !wr)[*8] ##1 (!rd && !wr) ##1 (!rd && !wr);
    endsequence

    // ************************************************************
    // properties
    // ************************************************************
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("link read data not zero outside answer cycle");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("link write and read strobes together");
    a_param_first: assert property (cmd_wr |-> $past(wr && addr == HCM_POOL_BASE_ADDR))
        else $error("command written without parameter word just before");
    a_code_top: assert property (cmd_wr |-> wdata[HCM_PEND_BIT])
        else $error("command code without top bit");
    a_poll_wait: assert property (cmd_wr |=> link_quiet ##1 (rd && addr == HCM_CMD_WORD_ADDR))
        else $error("first poll not ten cycles after command");
    a_poll_space: assert property (rd |=> (!rd)[*8])
        else $error("polls closer than poll delay");
    a_pend_hold: assert property (rd ##1 rdata[HCM_PEND_BIT] |-> (!wr)[*8])
        else $error("link write while command pending");
    a_addr_map: assert property (wr |-> addr == HCM_CMD_WORD_ADDR
                                 || addr[15:3] == HCM_POOL_BASE_ADDR[15:3])
        else $error("link write outside command word and pool");
endmodule : hcm_link_asserts

// ==== bench/test_host_command_mailbox.sv ====
`timescale 1ns/1ps
module test_host_command_mailbox
    import hcm_pkg::*;
;
    logic        mclk, srst, sw_wr, sw_rd, irq, irq_exp;
    logic [3:0]  sw_addr;
    logic [15:0] sw_wdata, sw_rdata, exec_result, cmd_code, sys_state, code_seen, v, n0;
    logic [15:0] irq_seen   = 16'h0000;
    logic        cmd_irq, cmd_valid, cmd_async;
    logic        exec_done  = 1'b0;
    logic        seen_async = 1'b0;
    int          fail_count, compares, exec_delay, i;
    int          dly_cnt    = 0;
    // sync/async classes; async mask bit per index
    logic [15:0] codes [27] = '{16'h8101, 16'h8200, 16'h8206, 16'h8207, 16'h820e,
        16'h8400, 16'h8405, 16'h8500, 16'h8501, 16'h8502, 16'h8503, 16'h8504,
        16'h8505, 16'h8506, 16'h8507, 16'h8508, 16'h8509, 16'h850a, 16'h8606,
        16'h8607, 16'h8700, 16'h8701, 16'h8702, 16'h8706, 16'h8900, 16'h8901, 16'h8902};
    logic [26:0] async_map = 27'h050f894;
    logic [15:0] bad_codes [3] = '{16'h820f, 16'h8300, 16'h8703};

    hcm_link_if hcm_link_if_i ();
    hcm_device hcm_device_i (.mclk(mclk), .srst(srst), .ce(1'b1), .link(hcm_link_if_i),
        .cmd_irq(cmd_irq), .cmd_code(cmd_code), .cmd_valid(cmd_valid), .cmd_async(cmd_async),
        .exec_done(exec_done), .exec_result(exec_result), .pool_we(1'b0), .pool_waddr(3'h0),
        .pool_wdata(16'h0000), .sys_state(sys_state));
    hcm_host hcm_host_i (.mclk(mclk), .srst(srst), .ce(1'b1), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq), .link(hcm_link_if_i));
    hcm_link_asserts hcm_link_asserts_i (.mclk(mclk), .srst(srst), .wr(hcm_link_if_i.wr),
        .rd(hcm_link_if_i.rd), .addr(hcm_link_if_i.addr), .wdata(hcm_link_if_i.wdata),
        .rdata(hcm_link_if_i.rdata));

    // ************************************************************
    // executor stand-in: a delay of zero never completes
    // ************************************************************
    always @(posedge mclk) begin
        exec_done <= 1'b0;
        if (cmd_irq) begin
            seen_async <= cmd_async;
            code_seen  <= cmd_code;
            irq_seen   <= irq_seen + 16'h0001;
            dly_cnt    <= exec_delay;
        end else if (dly_cnt != 0) begin
            dly_cnt <= dly_cnt - 1;
            if (dly_cnt == 1)
                exec_done <= 1'b1;
        end
    end

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic stop_test();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        sw_wr    <= 1'b1;
        sw_addr  <= a;
        sw_wdata <= d;
        @(posedge mclk);
        sw_wr <= 1'b0;
    endtask : sw_write

    task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        sw_rd   <= 1'b1;
        sw_addr <= a;
        @(posedge mclk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask : sw_read

    task automatic issue(input logic [15:0] code, input logic [15:0] param, input int dly,
                         input logic [15:0] res);
        exec_delay = dly;
        exec_result <= res;
        sw_write(HCM_R_PARAM0, param);
        sw_write(HCM_R_CODE, code);
        sw_write(HCM_R_CTRL, 16'h0001);
    endtask : issue

    task automatic run_cmd(input logic [15:0] code, input logic [15:0] param, input int dly,
                           input logic [15:0] res, input logic [15:0] exp_res, input logic [15:0] exp_ev);
        int n;
        logic [15:0] r;
        issue(code, param, dly, res);
        n = 0;
        r = 16'h0001;
        while (r[0] !== 1'b0 && n < 1000) begin
            sw_read(HCM_R_STATUS, r);
            n = n + 1;
        end
        if (n == 1000) begin
            fail_count = fail_count + 1;
            stop_test();
        end
        check({15'h0000, irq}, {15'h0000, irq_exp});
        sw_read(HCM_R_RESULT, r);
        check(r, exp_res);
        check(cmd_code, exp_res);
        check({15'h0000, cmd_valid}, 16'h0000);
        sw_read(HCM_R_IRQ_STAT, r);
        check(r & 16'h0006, exp_ev);
        sw_read(HCM_R_IRQ_STAT, r);
        check(r, 16'h0000);
        check({15'h0000, irq}, 16'h0000);
    endtask : run_cmd

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        srst = 1'b1;
        sw_wr = 1'b0;
        sw_rd = 1'b0;
        sw_addr = 4'h0;
        sw_wdata = 16'h0000;
        exec_result = 16'h0000;
        exec_delay = 0;
        fail_count = 0;
        compares = 0;
        irq_exp = 1'b1;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        sw_write(HCM_R_IRQ_MASK, 16'h0007);
        sw_read(HCM_R_IRQ_MASK, v);
        check(v, 16'h0007);
        run_cmd(HCM_SYS_SET, 16'h2800, 4, 16'h0000, HCM_RESULT_OK, 16'h0000);
        check(sys_state, 16'h2800);
        $display("test state request done");
        for (i = 0; i < 27; i++) begin
            n0 = irq_seen;
            run_cmd(codes[i], 16'(i), 3, 16'h0000, HCM_RESULT_OK, 16'h0000);
            check(irq_seen - n0, 16'h0001);
            check(code_seen, codes[i]);
            check({15'h0000, seen_async}, {15'h0000, async_map[i]});
        end
        $display("test command classes done");
        for (i = 0; i < 3; i++) begin
            n0 = irq_seen;
            run_cmd(bad_codes[i], 16'h0000, 3, 16'h0000, HCM_RESULT_BADCMD, 16'h0002);
            check(irq_seen, n0);
        end
        $display("test unknown codes done");
        run_cmd(HCM_GPIO_FIRST, 16'h0000, 6, 16'h0005, 16'h0005, 16'h0002);
        sw_write(HCM_R_IRQ_MASK, 16'h0000);
        irq_exp = 1'b0;
        run_cmd(HCM_SYS_GET, 16'h0000, 2, 16'h0000, HCM_RESULT_OK, 16'h0000);
        $display("test failure and mask done");
        issue(HCM_UTIL_WAIT, 16'h0000, 0, 16'h0000);
        i = 0;
        v = 16'h0000;
        while (v[HCM_EV_TIMEOUT] !== 1'b1 && i < 1000) begin
            sw_read(HCM_R_IRQ_STAT, v);
            i = i + 1;
        end
        check({15'h0000, v[HCM_EV_TIMEOUT]}, 16'h0001);
        $display("test poll timeout done");
        stop_test();
    end
endmodule : test_host_command_mailbox
